/* hw/mar_top.sv */
// alarm detection, classification and recording for a servo driver
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Notes on behaviour
// [RULE1] travel beyond +/-7FFFFFFFh raises 01h
// [RULE2] wrap operation while wrap disabled raises 02h
// [RULE3] nonzero travel at zero speed raises 03h
// [RULE4] sensor limits checked give 04h, 05h, 08h
// [RULE5] limit source 0 follows sensor, default 0
// [RULE6] input snapshot: virtual 15:12, event 10, direct 5:0
// [RULE7] remote output snapshot holds outputs 15..8
// [RULE8] info0 is -1 or running data number
// [RULE9] info0 keeps last number while stopped
// [RULE10] info1 encodes the active operation type
// [RULE11] overheat 85C, overvoltage 400V, command speed 15000
// [RULE12] non-excitation alarm cuts motor current
// [RULE13] excitation alarm keeps current and position
// [RULE14] deviation alarm 10h, 4 blinks, any reset
// [RULE15] short circuit 20h, 5 blinks, power-cycle only
// [RULE16] driver overheat 21h, 2 blinks, any reset
// [RULE17] alarm raises active-high output, drops inverted, stops
// [RULE18] clear acts only on rising clear input; net_alarm_clear also clears, on its level with no edge detect
// [RULE19] ten newest records kept, newest first
// [RULE20] all snapshot fields caught in detection cycle
// ----------------------------------------
module mar_top
    import mar_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // operation start request
    input  wire logic                        op_start,
    input  wire logic                        op_positioning,
    input  wire logic                        op_uses_wrap,
    input  wire logic                        wrap_enabled,
    input  wire logic signed [TRAVEL_W-1:0]  travel_amount,
    input  wire logic [31:0]                 cmd_speed_hz,
    input  wire logic [31:0]                 start_speed_hz,
    input  wire logic [31:0]                 sensor_max_speed_hz,
    input  wire logic [31:0]                 sensor_max_start_hz,
    input  wire logic                        homing_over_sensor,
    input  wire logic                        protection_limit_source,
    // running operation
    input  wire logic [3:0]                  op_type,
    input  wire logic                        op_uses_data,
    input  wire logic [7:0]                  op_data_number,
    // monitored quantities
    input  wire logic signed [15:0]          driver_temp_c,
    input  wire logic signed [15:0]          motor_temp_c,
    input  wire logic [15:0]                 inverter_volt_v,
    input  wire logic [15:0]                 cmd_speed_rpm,
    input  wire logic                        motor_excited,
    input  wire logic                        deviation_over,
    input  wire logic                        output_short,
    // io to snapshot
    input  wire logic [3:0]                  virtual_input,
    input  wire logic                        external_event_input,
    input  wire logic [5:0]                  direct_input,
    input  wire logic [7:0]                  remote_output_hi,
    // alarm clearing and history access
    input  wire logic                        alarm_clear_input,
    input  wire logic                        net_alarm_clear,
    input  wire logic                        net_history_clear,
    input  wire logic [3:0]                  history_index,
    // alarm outputs
    output logic                             alarm_out_active_high,
    output logic                             alarm_out_inverted,
    output logic                             motor_stop,
    output logic                             motor_current_on,
    output logic [3:0]                       led_blinks,
    output logic [7:0]                       alarm_code,
    output logic [7:0]                       alarm_sub_code,
    // live operation information
    output logic signed [8:0]                op_info0,
    output logic [3:0]                       op_info1,
    // history read data
    output logic [REC_W-1:0]                 history_record,
    output logic [3:0]                       history_count
);
    // ----------------------------------------
    // alarm attributes
    // ----------------------------------------
    // blinks, power-cycle-only flag, excitation kept flag
    function automatic logic [5:0] alarm_attr(input logic [7:0] code);
        logic [5:0] a;
        a = 6'h00;
        case (code)
            ALM_DEVIATION: a = {BLINK_DEVIATION, 1'b0, 1'b0}; // [RULE14]
            ALM_SHORT:     a = {BLINK_SHORT, 1'b1, 1'b0};     // [RULE15]
            ALM_DRV_HOT:   a = {BLINK_DRV_HOT, 1'b0, 1'b0};   // [RULE16]
            ALM_OVERVOLT:  a = {BLINK_OVERVOLT, 1'b1, 1'b0};
            ALM_MOT_HOT:   a = {BLINK_MOT_HOT, 1'b0, 1'b0};
            ALM_CMD_POS:   a = {BLINK_CMD_POS, 1'b0, 1'b0};
            ALM_OP_DATA:   a = {BLINK_OP_DATA, 1'b0, 1'b1};   // [RULE13]
            default:       a = 6'h00;
        endcase
        return a;
    endfunction : alarm_attr

    // ----------------------------------------
    // operation data error decode
    // ----------------------------------------
    logic       prot_src_q;
    logic [7:0] sub_d;
    logic       follow_sensor;

    // limit source register, 0 after reset [RULE5]
    always_ff @(posedge clk) begin
        if (rst) begin
            prot_src_q <= PROT_RESET_VALUE;
        end else begin
            prot_src_q <= protection_limit_source;
        end
    end
    assign follow_sensor = (prot_src_q == PROT_FOLLOW_SENSOR);

    // lowest sub code wins when several causes coincide
    always_comb begin
        sub_d = SUB_NONE;
        if (op_start) begin
            if (op_positioning && (travel_amount > TRAVEL_MAX || travel_amount < -TRAVEL_MAX)) begin
                sub_d = SUB_TRAVEL; // [RULE1]
            end else if (op_uses_wrap && !wrap_enabled) begin
                sub_d = SUB_WRAP; // [RULE2]
            end else if (op_positioning && travel_amount != '0 && cmd_speed_hz == 32'h0) begin
                sub_d = SUB_ZERO_SPD; // [RULE3]
            end else if (follow_sensor && cmd_speed_hz > sensor_max_speed_hz) begin
                sub_d = SUB_OP_SPD; // [RULE4]
            end else if (follow_sensor && start_speed_hz > sensor_max_start_hz) begin
                sub_d = SUB_START_SPD; // [RULE4]
            end else if (follow_sensor && homing_over_sensor) begin
                sub_d = SUB_HOMING; // [RULE4]
            end
        end
    end

    // ----------------------------------------
    // alarm detection
    // ----------------------------------------
    logic [7:0] code_d;

    // fixed priority, hardware faults before data errors
    always_comb begin
        if (output_short) begin
            code_d = ALM_SHORT; // [RULE15]
        end else if (inverter_volt_v > VOLT_LIMIT_V) begin
            code_d = ALM_OVERVOLT; // [RULE11]
        end else if (driver_temp_c > TEMP_LIMIT_C) begin
            code_d = ALM_DRV_HOT; // [RULE11] [RULE16]
        end else if (motor_temp_c > TEMP_LIMIT_C) begin
            code_d = ALM_MOT_HOT; // [RULE11]
        end else if (motor_excited && deviation_over) begin
            code_d = ALM_DEVIATION; // [RULE14]
        end else if (cmd_speed_rpm > CMD_SPD_LIMIT_RPM) begin
            code_d = ALM_CMD_POS; // [RULE11]
        end else if (sub_d != SUB_NONE) begin
            code_d = ALM_OP_DATA;
        end else begin
            code_d = ALM_NONE;
        end
    end

    // ----------------------------------------
    // operation information
    // ----------------------------------------
    logic signed [8:0] info0_q;
    logic [3:0]        info1_q;

    // -1 at power-up, held through stops [RULE8] [RULE9]
    always_ff @(posedge clk) begin
        if (rst) begin
            info0_q <= OPINFO0_NONE; // [RULE8]
        end else if (op_type != OPT_STOPPED) begin
            info0_q <= op_uses_data ? $signed({1'b0, op_data_number}) : OPINFO0_NONE; // [RULE8]
        end
    end

    // operation type passed through as registered code [RULE10]
    always_ff @(posedge clk) begin
        if (rst) begin
            info1_q <= OPT_STOPPED;
        end else begin
            info1_q <= op_type; // [RULE10]
        end
    end

    // ----------------------------------------
    // alarm latch and clearing
    // ----------------------------------------
    logic             clr_prev_q;
    logic             clear_req;
    logic             active_q;
    logic [7:0]       code_q;
    logic [7:0]       sub_q;
    logic [5:0]       attr_q;
    logic             new_alarm;
    logic [REC_W-1:0] rec_now;
    logic             hold_excite;
    logic [5:0]       attr_now;

    // previous clear level for edge detect
    always_ff @(posedge clk) begin
        if (rst) begin
            clr_prev_q <= 1'b1; // a level high at release is not an edge
        end else begin
            clr_prev_q <= alarm_clear_input;
        end
    end
    assign clear_req = (alarm_clear_input && !clr_prev_q) || net_alarm_clear; // [RULE18]
    assign new_alarm = !active_q && code_d != ALM_NONE;
    assign attr_now  = alarm_attr(code_d);

    // record assembled from live inputs in the detecting cycle [RULE20]
    assign rec_now = {code_d, (code_d == ALM_OP_DATA) ? sub_d : SUB_NONE,
                      virtual_input, 1'b0, external_event_input, 4'h0, direct_input, // [RULE6]
                      remote_output_hi,                                              // [RULE7]
                      info0_q, op_type};

    // first alarm latches; a cause present in the clear cycle latches one cycle after the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= 1'b0;
            code_q   <= ALM_NONE;
            sub_q    <= SUB_NONE;
            attr_q   <= 6'h00;
        end else if (new_alarm) begin
            active_q <= 1'b1;
            code_q   <= code_d;
            sub_q    <= rec_now[REC_SUB +: 8];
            attr_q   <= attr_now;
        end else if (active_q && clear_req && !attr_q[1]) begin
            active_q <= 1'b0; // power-cycle-only alarms ignore this [RULE15]
            code_q   <= ALM_NONE;
            sub_q    <= SUB_NONE;
            attr_q   <= 6'h00;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hold_excite = new_alarm ? attr_now[0] : attr_q[0];

    // all outputs registered; the alarm shows one edge after detection
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_out_active_high <= 1'b0;
            alarm_out_inverted    <= 1'b1;
            motor_stop            <= 1'b0;
            motor_current_on      <= 1'b1;
            led_blinks            <= 4'h0;
            alarm_code            <= ALM_NONE;
            alarm_sub_code        <= SUB_NONE;
        end else begin
            alarm_out_active_high <= new_alarm || (active_q && !(clear_req && !attr_q[1])); // [RULE17]
            alarm_out_inverted    <= !(new_alarm || (active_q && !(clear_req && !attr_q[1]))); // [RULE17]
            motor_stop            <= new_alarm || (active_q && !(clear_req && !attr_q[1])); // [RULE17]
            // current cut unless the alarm keeps excitation [RULE12] [RULE13]
            motor_current_on      <= !(new_alarm || (active_q && !(clear_req && !attr_q[1]))) || hold_excite;
            led_blinks            <= new_alarm ? attr_now[5:2] : (clear_req && !attr_q[1]) ? 4'h0 : attr_q[5:2];
            alarm_code            <= new_alarm ? code_d : (clear_req && !attr_q[1]) ? ALM_NONE : code_q;
            alarm_sub_code        <= new_alarm ? rec_now[REC_SUB +: 8] : (clear_req && !attr_q[1]) ? SUB_NONE : sub_q;
        end
    end

    // live operation info and history mirrors
    logic [REC_W-1:0] hist_rd;
    logic [3:0]       hist_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            op_info0       <= OPINFO0_NONE;
            op_info1       <= OPT_STOPPED;
            history_record <= '0;
            history_count  <= 4'h0;
        end else begin
            op_info0       <= info0_q;
            op_info1       <= info1_q;
            history_record <= hist_rd;
            history_count  <= hist_cnt;
        end
    end

    // ----------------------------------------
    // history store
    // ----------------------------------------
    mar_history u_history (
        .clk      (clk),
        .rst      (rst),
        .push     (new_alarm), // [RULE19]
        .push_rec (rec_now),
        .clear    (net_history_clear),
        .rd_index (history_index),
        .rd_rec   (hist_rd),
        .count    (hist_cnt)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_short_latch: assert property (@(posedge clk) disable iff (rst)
        !active_q && output_short |=> active_q && code_q == ALM_SHORT && attr_q[5:2] == 4'h5)
        else $error("short circuit not latched as 20h"); // [RULE15]
    a_short_no_clear: assert property (@(posedge clk) disable iff (rst)
        active_q && code_q == ALM_SHORT |=> active_q)
        else $error("short circuit alarm cleared without power cycle"); // [RULE15]
    a_dev_blinks: assert property (@(posedge clk) disable iff (rst)
        new_alarm && code_d == ALM_DEVIATION |=> led_blinks == 4'h4 && !motor_current_on)
        else $error("deviation alarm wrong blinks or excitation"); // [RULE14]
    a_hot_blinks: assert property (@(posedge clk) disable iff (rst)
        new_alarm && code_d == ALM_DRV_HOT |=> led_blinks == 4'h2 && alarm_code == 8'h21)
        else $error("driver overheat wrong code or blinks"); // [RULE16]
    a_alarm_pins: assert property (@(posedge clk) disable iff (rst)
        new_alarm |=> alarm_out_active_high && !alarm_out_inverted && motor_stop)
        else $error("alarm pins not asserted"); // [RULE17]
    a_clear_edge: assert property (@(posedge clk) disable iff (rst)
        active_q && !new_alarm && alarm_clear_input && $past(alarm_clear_input) && !net_alarm_clear
        |=> active_q)
        else $error("clear acted on a level"); // [RULE18]
    a_travel_sub: assert property (@(posedge clk) disable iff (rst)
        new_alarm && op_start && op_positioning && travel_amount > TRAVEL_MAX && code_d == ALM_OP_DATA
        |=> alarm_sub_code == 8'h01)
        else $error("travel overrange sub code wrong"); // [RULE1]
    a_zero_speed: assert property (@(posedge clk) disable iff (rst)
        op_start && op_positioning && travel_amount != '0 && travel_amount <= TRAVEL_MAX
        && travel_amount >= -TRAVEL_MAX && cmd_speed_hz == 32'h0 && !(op_uses_wrap && !wrap_enabled)
        |-> sub_d == SUB_ZERO_SPD)
        else $error("zero speed sub code missing"); // [RULE3]
    a_opdata_excite: assert property (@(posedge clk) disable iff (rst)
        new_alarm && code_d == ALM_OP_DATA |=> motor_current_on ##1 motor_current_on || !active_q)
        else $error("operation data alarm cut current"); // [RULE13]
    a_info0_hold: assert property (@(posedge clk) disable iff (rst)
        op_type == OPT_STOPPED |=> info0_q == $past(info0_q))
        else $error("info0 changed while stopped"); // [RULE9]
    a_snap_input: assert property (@(posedge clk) disable iff (rst)
        new_alarm |-> rec_now[REC_IN +: 16] == {virtual_input, 1'b0, external_event_input, 4'h0, direct_input})
        else $error("input snapshot misplaced"); // [RULE6] [RULE20]

    c_short_alarm: cover property (@(posedge clk) disable iff (rst) new_alarm && code_d == ALM_SHORT);
    c_data_error: cover property (@(posedge clk) disable iff (rst) new_alarm && code_d == ALM_OP_DATA);
    c_clear_done: cover property (@(posedge clk) disable iff (rst) active_q ##1 !active_q);
    c_hist_full: cover property (@(posedge clk) disable iff (rst) hist_cnt == 4'(HIST_DEPTH));
endmodule : mar_top
`default_nettype wire

/* hw/mar_pkg.sv */
// package of alarm recorder constants and the alarm history store
`timescale 1ns/1ps
`default_nettype none
package mar_pkg;
    // ----------------------------------------
    // alarm codes
    // ----------------------------------------
    localparam logic [7:0] ALM_NONE      = 8'h00;
    localparam logic [7:0] ALM_DEVIATION = 8'h10;
    localparam logic [7:0] ALM_SHORT     = 8'h20;
    localparam logic [7:0] ALM_DRV_HOT   = 8'h21;
    localparam logic [7:0] ALM_OVERVOLT  = 8'h22;
    localparam logic [7:0] ALM_MOT_HOT   = 8'h26;
    localparam logic [7:0] ALM_CMD_POS   = 8'h34;
    localparam logic [7:0] ALM_OP_DATA   = 8'h70;
    // ----------------------------------------
    // operation data error sub codes
    // ----------------------------------------
    localparam logic [7:0] SUB_NONE      = 8'h00;
    localparam logic [7:0] SUB_TRAVEL    = 8'h01;
    localparam logic [7:0] SUB_WRAP      = 8'h02;
    localparam logic [7:0] SUB_ZERO_SPD  = 8'h03;
    localparam logic [7:0] SUB_OP_SPD    = 8'h04;
    localparam logic [7:0] SUB_START_SPD = 8'h05;
    localparam logic [7:0] SUB_HOMING    = 8'h08;
    // ----------------------------------------
    // thresholds and limits
    // ----------------------------------------
    localparam int TRAVEL_W = 40;
    localparam logic signed [39:0] TRAVEL_MAX = 40'sh007fffffff;
    localparam logic signed [15:0] TEMP_LIMIT_C = 16'sh0055;     // 85 degC
    localparam logic [15:0] VOLT_LIMIT_V = 16'h0190;             // 400 V
    localparam logic [15:0] CMD_SPD_LIMIT_RPM = 16'h3a98;        // 15000 r/min
    localparam logic PROT_FOLLOW_SENSOR = 1'b0;
    localparam logic PROT_RESET_VALUE   = 1'b0;
    // ----------------------------------------
    // led blink counts
    // ----------------------------------------
    localparam logic [3:0] BLINK_DEVIATION = 4'h4;
    localparam logic [3:0] BLINK_SHORT     = 4'h5;
    localparam logic [3:0] BLINK_DRV_HOT   = 4'h2;
    localparam logic [3:0] BLINK_OVERVOLT  = 4'h3;
    localparam logic [3:0] BLINK_MOT_HOT   = 4'h8;
    localparam logic [3:0] BLINK_CMD_POS   = 4'h7;
    localparam logic [3:0] BLINK_OP_DATA   = 4'h7;
    // ----------------------------------------
    // operation information
    // ----------------------------------------
    localparam logic signed [8:0] OPINFO0_NONE = 9'sh1ff;        // -1
    localparam logic [3:0] OPT_STOPPED = 4'h0;
    localparam logic [3:0] OPT_STORED  = 4'h1;
    localparam logic [3:0] OPT_DIRECT  = 4'h2;
    localparam logic [3:0] OPT_HOME    = 4'h3;
    localparam logic [3:0] OPT_HS_HOME = 4'h4;
    localparam logic [3:0] OPT_JOG     = 4'h5;
    localparam logic [3:0] OPT_HS_JOG  = 4'h6;
    localparam logic [3:0] OPT_CMB_JOG = 4'h7;
    localparam logic [3:0] OPT_INCH    = 4'h8;
    localparam logic [3:0] OPT_CONT    = 4'h9;
    localparam logic [3:0] OPT_TEACH   = 4'hd;
    // ----------------------------------------
    // history record layout
    // ----------------------------------------
    localparam int HIST_DEPTH = 10;
    localparam int REC_W      = 53;
    localparam int REC_CODE   = 45;   // [52:45]
    localparam int REC_SUB    = 37;   // [44:37]
    localparam int REC_IN     = 21;   // [36:21]
    localparam int REC_ROUT   = 13;   // [20:13]
    localparam int REC_INFO0  = 4;    // [12:4]
    localparam int REC_INFO1  = 0;    // [3:0]
endpackage : mar_pkg

// newest-first shift store of alarm records
module mar_history
    import mar_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // write side
    input  wire logic             push,
    input  wire logic [REC_W-1:0] push_rec,
    input  wire logic             clear,
    // read side
    input  wire logic [3:0]       rd_index,
    output logic      [REC_W-1:0] rd_rec,
    output logic      [3:0]       count
);
    logic [REC_W-1:0] mem_q [HIST_DEPTH];
    logic [3:0]       count_q;

    // newest lands in slot 0, the oldest falls off the end [RULE19]
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[0] <= push_rec;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                mem_q[i] <= mem_q[i-1];
            end
        end
    end

    // number of valid entries, saturating at the depth
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 4'h0;
        end else if (clear) begin
            count_q <= {3'h0, push}; // a push in the clear cycle survives
        end else if (push && count_q != 4'(HIST_DEPTH)) begin
            count_q <= count_q + 4'h1;
        end
    end

    // empty and out-of-range slots read as zero
    always_comb begin
        if (rd_index < count_q) begin
            rd_rec = mem_q[rd_index];
        end else begin
            rd_rec = '0;
        end
    end
    assign count = count_q;

    a_hist_count_step: assert property (@(posedge clk) disable iff (rst)
        push && !clear && $past(count_q) == count_q && count_q < 4'(HIST_DEPTH) |=> count_q == $past(count_q) + 4'h1)
        else $error("history count did not advance on push"); // [RULE19]
endmodule : mar_history
`default_nettype wire

/* tb/mar_host_model.sv */
// host controller model: alarm clearing and history reads
`timescale 1ns/1ps
`default_nettype none
module mar_host_model
    import mar_pkg::*;
(
    // clock
    input  wire logic             clk,
    // host side of the recorder
    output logic      [3:0]       history_index,
    output logic                  alarm_clear_input,
    output logic                  net_alarm_clear,
    input  wire logic [REC_W-1:0] history_record
);
    initial begin
        history_index = 4'h0;
        alarm_clear_input = 1'b0;
        net_alarm_clear = 1'b0;
    end
    // index decoded at once, record registered at the next edge
    task automatic read_rec(input logic [3:0] idx, output logic [REC_W-1:0] rec);
        @(negedge clk) history_index = idx;
        repeat (2) @(negedge clk);
        rec = history_record;
    endtask : read_rec
    // only the off-to-on change counts, so drop the line first
    task automatic clear_edge();
        @(negedge clk) alarm_clear_input = 1'b0;
        @(negedge clk) alarm_clear_input = 1'b1;
    endtask : clear_edge
    task automatic net_clear();
        @(negedge clk) net_alarm_clear = 1'b1;
        @(negedge clk) net_alarm_clear = 1'b0;
    endtask : net_clear
endmodule : mar_host_model
`default_nettype wire

/* tb/mar_top_tb.sv */
// self-checking bench for the alarm recorder
`timescale 1ns/1ps
`default_nettype none
module mar_top_tb import mar_pkg::*;;
    logic clk = 0, rst = 1, op_start = 0, op_positioning = 1, op_uses_wrap = 0, wrap_enabled = 0;
    logic homing_over_sensor = 0, protection_limit_source = 0, op_uses_data = 0, motor_excited = 0;
    logic deviation_over = 0, output_short = 0, external_event_input = 0, net_history_clear = 0;
    logic alarm_clear_input, net_alarm_clear, alarm_out_active_high, alarm_out_inverted, motor_stop, motor_current_on;
    logic signed [TRAVEL_W-1:0] travel_amount = '0;
    logic [31:0] cmd_speed_hz = '0, start_speed_hz = '0, sensor_max_speed_hz = 32'h3e8, sensor_max_start_hz = 32'h3e8;
    logic [3:0] op_type = '0, virtual_input = '0, history_index, led_blinks, op_info1, history_count;
    logic [7:0] op_data_number = '0, remote_output_hi = '0, alarm_code, alarm_sub_code;
    logic signed [15:0] driver_temp_c = 16'sh0019, motor_temp_c = 16'sh0019;
    logic [15:0] inverter_volt_v = 16'h012c, cmd_speed_rpm = '0;
    logic [5:0] direct_input = '0;
    logic signed [8:0] op_info0;
    logic [REC_W-1:0] history_record, rec;
    int errors = 0, n_compared = 0;
    initial forever #25 clk = ~clk;
    mar_top u_dut (.*);
    mar_host_model u_host (.clk, .history_index, .alarm_clear_input, .net_alarm_clear, .history_record);
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic do_rst();
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(1);
    endtask : do_rst
    // short circuit survives a clear edge; only reset removes it
    task automatic t_short();
        output_short = 1'b1;
        cyc(3);
        output_short = 1'b0;
        chk({alarm_code, led_blinks}, {ALM_SHORT, BLINK_SHORT});
        chk({alarm_out_active_high, alarm_out_inverted, motor_stop, motor_current_on}, 4'ha);
        u_host.clear_edge();
        cyc(3);
        chk(alarm_code, ALM_SHORT);
        do_rst();
        chk({alarm_out_inverted, op_info0, history_count}, {1'b1, OPINFO0_NONE, 4'h0});
    endtask : t_short
    // clear line already high when the alarm rises must not clear it
    task automatic t_hot();
        op_type = OPT_STORED;
        op_uses_data = 1'b1;
        op_data_number = 8'h05;
        {virtual_input, external_event_input, direct_input, remote_output_hi} = {4'ha, 1'b1, 6'h2a, 8'h5c};
        driver_temp_c = 16'sh0055;
        cyc(3);
        chk(alarm_code, ALM_NONE);
        driver_temp_c = 16'sh0056;
        cyc(3);
        driver_temp_c = 16'sh0019;
        chk({alarm_code, led_blinks, motor_current_on}, {ALM_DRV_HOT, BLINK_DRV_HOT, 1'b0});
        chk({op_info0, op_info1}, {9'h005, OPT_STORED});
        cyc(2);
        chk({alarm_code, history_count}, {ALM_DRV_HOT, 4'h1});
        u_host.read_rec(4'h0, rec);
        chk(rec, {ALM_DRV_HOT, SUB_NONE, 16'ha42a, 8'h5c, 9'h005, OPT_STORED});
        u_host.clear_edge();
        cyc(2);
        chk(alarm_code, ALM_NONE);
        op_type = OPT_STOPPED;
        cyc(2);
        chk(op_info0, 9'h005);
    endtask : t_hot
    task automatic t_dev();
        deviation_over = 1'b1;
        cyc(3);
        chk(alarm_code, ALM_NONE);
        motor_excited = 1'b1;
        cyc(3);
        deviation_over = 1'b0;
        chk({alarm_code, led_blinks, motor_current_on}, {ALM_DEVIATION, BLINK_DEVIATION, 1'b0});
        u_host.net_clear();
        cyc(2);
        chk(alarm_code, ALM_NONE);
        u_host.read_rec(4'h1, rec);
        chk({history_count, rec[REC_W-1 -: 8]}, {4'h2, ALM_DRV_HOT});
    endtask : t_dev
    // limit source is registered, so it settles a cycle before start
    task automatic st(input logic [39:0] tr, input logic [31:0] spd, input logic wr, hm, src, input logic [7:0] sub);
        {travel_amount, cmd_speed_hz, op_uses_wrap, homing_over_sensor, protection_limit_source} = {tr, spd, wr, hm, src};
        cyc(1);
        op_start = 1'b1;
        cyc(1);
        op_start = 1'b0;
        cyc(2);
        chk({alarm_code, alarm_sub_code}, {(sub != 8'h00) ? ALM_OP_DATA : ALM_NONE, sub});
        chk(motor_current_on, 1'b1);
        u_host.net_clear();
        cyc(2);
    endtask : st
    // boundary values sit beside each over-threshold value
    task automatic t_thr();
        for (int i = 0; i < 3; i++) begin
            motor_temp_c = (i == 0) ? 16'sh0056 : 16'sh0055;
            inverter_volt_v = (i == 1) ? 16'h0191 : 16'h0190;
            cmd_speed_rpm = (i == 2) ? 16'h3a99 : 16'h3a98;
            cyc(3);
            chk(alarm_code, (i == 0) ? ALM_MOT_HOT : (i == 1) ? ALM_OVERVOLT : ALM_CMD_POS);
            {motor_temp_c, inverter_volt_v, cmd_speed_rpm} = {16'sh0019, 16'h012c, 16'h0000};
            do_rst();
        end
    endtask : t_thr
    initial begin
        do_rst();
        t_short();
        t_hot();
        t_dev();
        st(40'sh0080000000, 32'h64, 0, 0, 0, SUB_TRAVEL);
        st(40'shff80000001, 32'h64, 0, 0, 0, SUB_NONE);
        st(40'shff80000000, 32'h64, 0, 0, 0, SUB_TRAVEL);
        st(40'sh000000000a, 32'h64, 1, 0, 0, SUB_WRAP);
        st(40'sh000000000a, 32'h00, 0, 0, 0, SUB_ZERO_SPD);
        st(40'sh000000000a, 32'h7d0, 0, 0, 0, SUB_OP_SPD);
        start_speed_hz = 32'h7d0;
        st(40'sh000000000a, 32'h64, 0, 0, 0, SUB_START_SPD);
        start_speed_hz = '0;
        st(40'sh000000000a, 32'h7d0, 0, 1, 1, SUB_NONE);
        st(40'sh000000000a, 32'h64, 0, 1, 0, SUB_HOMING);
        t_thr();
        report_and_stop();
    end
    // the whole run needs some 160 cycles; this cuts a hang
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
endmodule : mar_top_tb
`default_nettype wire
